/* File: design/wdt_reload_cause.sv */
// Behaviour
// - control write and reset-cause read share one address.
// - all eight control bits form one write-only unlock field.
// - cause bits: power-on 7, stop recovery 6, watchdog 5, pin 4; rest zero.
// - 24-bit reload in three bytes: upper, high, low at consecutive addresses.
// - reading a reload byte returns that byte of the live count.
// - writing a reload byte stores it into the reload value.
// - reload resets to upper 00, high 04, low 00.
// - the two addresses after the low byte hold nothing.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
module wdt_reload_cause
(
   input  wire logic        sys_clk,        // system clock, 250 MHz
   input  wire logic        reset,          // synchronous reset, active high
   input  wire logic        hsel,           // slave select
   input  wire logic [31:0] haddr,          // byte address
   input  wire logic [1:0]  htrans,         // transfer type
   input  wire logic        hwrite,         // write when high
   input  wire logic [2:0]  hsize,          // transfer size, word only
   input  wire logic [31:0] hwdata,         // write data
   input  wire logic        hready,         // bus ready in
   output logic      [31:0] hrdata,         // read data
   output logic             hreadyout,      // slave ready
   output logic             hresp,          // response, always okay
   input  wire logic        por_event,      // power-on cause pulse
   input  wire logic        stop_event,     // stop-mode recovery cause pulse
   input  wire logic        ext_event,      // external pin cause pulse
   output logic             wdt_timeout,    // one-cycle timeout pulse
   output logic      [7:0]  unlock_code,    // last byte written to control
   output logic             unlock_strobe   // one-cycle pulse after a control write
);

   wdt_count_if cif ();

   wdt_counter u_counter
   (
      .sys_clk (sys_clk),
      .reset   (reset),
      .cnt     (cif.cnt)
   );

   // data-phase bookkeeping
   logic        wr_pend_ff;
   logic        nxt_wr_pend;
   logic [29:0] wr_idx_ff;
   logic [29:0] nxt_wr_idx;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;

   // register state
   logic [23:0] reload_ff;
   logic [23:0] nxt_reload;
   logic [7:0]  unlock_ff;
   logic [7:0]  nxt_unlock;
   logic        strobe_ff;
   logic        nxt_strobe;
   logic [3:0]  cause_ff;     // por, stop, wdt, ext from msb down
   logic [3:0]  nxt_cause;

   logic        take;
   logic [29:0] a_idx;
   logic [7:0]  wbyte;
   logic [7:0]  cause_byte;

   assign take  = hsel && htrans[wdt_pkg::HTRANS_ACTIVE_BIT] && hready;
   assign a_idx = haddr[31:2];
   assign wbyte = hwdata[7:0];

   // reserved low bits of the cause register read as zero
   always_comb
   begin
      cause_byte = 8'h00;
      cause_byte[wdt_pkg::POS_POR_CAUSE]  = cause_ff[3];
      cause_byte[wdt_pkg::POS_STOP_CAUSE] = cause_ff[2];
      cause_byte[wdt_pkg::POS_WDT_CAUSE]  = cause_ff[1];
      cause_byte[wdt_pkg::POS_EXT_CAUSE]  = cause_ff[0];
   end

   // address phase: latch write target, prepare read data now so the
   // data phase needs no wait state
   always_comb
   begin
      nxt_wr_pend = take && hwrite;
      nxt_wr_idx  = take ? a_idx : wr_idx_ff;
      nxt_rdata   = 32'h0000_0000;
      if (take && !hwrite)
      begin
         case (a_idx)
            wdt_pkg::IDX_CTRL_CAUSE:
               nxt_rdata = {24'h00_0000, cause_byte};
            wdt_pkg::IDX_RELOAD_UPPER:
               nxt_rdata = {24'h00_0000, wdt_pkg::get_byte(cif.count, wdt_pkg::LANE_UPPER)};
            wdt_pkg::IDX_RELOAD_HIGH:
               nxt_rdata = {24'h00_0000, wdt_pkg::get_byte(cif.count, wdt_pkg::LANE_HIGH)};
            wdt_pkg::IDX_RELOAD_LOW:
               nxt_rdata = {24'h00_0000, wdt_pkg::get_byte(cif.count, wdt_pkg::LANE_LOW)};
            default:
               nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         wr_pend_ff <= 1'b0;
         wr_idx_ff  <= 30'h0000_0000;
         rdata_ff   <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_ff <= nxt_wr_pend;
         wr_idx_ff  <= nxt_wr_idx;
         rdata_ff   <= nxt_rdata;
      end
   end

   // data phase: write lands; unmapped and reserved indices drop the data
   always_comb
   begin
      nxt_reload = reload_ff;
      nxt_unlock = unlock_ff;
      nxt_strobe = 1'b0;
      if (wr_pend_ff)
      begin
         case (wr_idx_ff)
            wdt_pkg::IDX_CTRL_CAUSE:
            begin
               nxt_unlock = wbyte;
               nxt_strobe = 1'b1;
            end
            wdt_pkg::IDX_RELOAD_UPPER:
               nxt_reload = wdt_pkg::set_byte(reload_ff, wdt_pkg::LANE_UPPER, wbyte);
            wdt_pkg::IDX_RELOAD_HIGH:
               nxt_reload = wdt_pkg::set_byte(reload_ff, wdt_pkg::LANE_HIGH, wbyte);
            wdt_pkg::IDX_RELOAD_LOW:
               nxt_reload = wdt_pkg::set_byte(reload_ff, wdt_pkg::LANE_LOW, wbyte);
            default:
               nxt_reload = reload_ff;
         endcase
      end
   end

   // cause bits are sticky; only the system reset clears them, so a
   // timeout that itself resets the chip clears its own flag with the rest
   always_comb
   begin
      nxt_cause    = cause_ff;
      nxt_cause[3] = cause_ff[3] | por_event;
      nxt_cause[2] = cause_ff[2] | stop_event;
      nxt_cause[1] = cause_ff[1] | cif.expired;
      nxt_cause[0] = cause_ff[0] | ext_event;
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         reload_ff <= wdt_pkg::RST_RELOAD;
         unlock_ff <= wdt_pkg::RST_UNLOCK;
         strobe_ff <= 1'b0;
         cause_ff  <= wdt_pkg::RST_CAUSE;
      end
      else
      begin
         reload_ff <= nxt_reload;
         unlock_ff <= nxt_unlock;
         strobe_ff <= nxt_strobe;
         cause_ff  <= nxt_cause;
      end
   end

   // a control write refreshes the count from the current reload
   assign cif.reload  = reload_ff;
   assign cif.restart = strobe_ff;

   assign hrdata        = rdata_ff;
   assign hreadyout     = 1'b1;      // zero wait states
   assign hresp         = 1'b0;
   assign wdt_timeout   = cif.expired;
   assign unlock_code   = unlock_ff;
   assign unlock_strobe = strobe_ff;

endmodule

/* File: design/wdt_pkg.sv */
package wdt_pkg;
   // register indices; byte address is four times the index
   localparam logic [29:0] IDX_CTRL_CAUSE  = 30'h0000_0FF0;
   localparam logic [29:0] IDX_RELOAD_UPPER = 30'h0000_0FF1;
   localparam logic [29:0] IDX_RELOAD_HIGH  = 30'h0000_0FF2;
   localparam logic [29:0] IDX_RELOAD_LOW   = 30'h0000_0FF3;

   // reset cause field positions
   localparam int POS_POR_CAUSE  = 7;
   localparam int POS_STOP_CAUSE = 6;
   localparam int POS_WDT_CAUSE  = 5;
   localparam int POS_EXT_CAUSE  = 4;

   // reset values
   localparam logic [7:0]  RST_RELOAD_UPPER = 8'h00;
   localparam logic [7:0]  RST_RELOAD_HIGH  = 8'h04;
   localparam logic [7:0]  RST_RELOAD_LOW   = 8'h00;
   localparam logic [23:0] RST_RELOAD       = {RST_RELOAD_UPPER, RST_RELOAD_HIGH, RST_RELOAD_LOW};
   localparam logic [7:0]  RST_UNLOCK       = 8'h00;
   localparam logic [3:0]  RST_CAUSE        = 4'h0;

   // byte lane numbering inside the 24-bit reload/count word
   localparam logic [1:0] LANE_LOW   = 2'h0;
   localparam logic [1:0] LANE_HIGH  = 2'h1;
   localparam logic [1:0] LANE_UPPER = 2'h2;

   // ahb transfer type bit that marks an active transfer
   localparam int HTRANS_ACTIVE_BIT = 1;

   // pick one byte out of a 24-bit word
   function automatic logic [7:0] get_byte(input logic [23:0] word, input logic [1:0] lane);
      logic [7:0] res;
      res = 8'h00;
      case (lane)
         LANE_LOW:   res = word[7:0];
         LANE_HIGH:  res = word[15:8];
         LANE_UPPER: res = word[23:16];
         default:    res = 8'h00;
      endcase
      return res;
   endfunction

   // replace one byte of a 24-bit word
   function automatic logic [23:0] set_byte(input logic [23:0] word, input logic [1:0] lane,
                                            input logic [7:0] val);
      logic [23:0] res;
      res = word;
      case (lane)
         LANE_LOW:   res[7:0]   = val;
         LANE_HIGH:  res[15:8]  = val;
         LANE_UPPER: res[23:16] = val;
         default:    res = word;
      endcase
      return res;
   endfunction
endpackage

/* File: design/wdt_count_if.sv */
`timescale 1ns/100ps
interface wdt_count_if;
   logic [23:0] reload;   // reload value from the register file
   logic        restart;  // one-cycle pulse: reload the count now
   logic [23:0] count;    // live count
   logic        expired;  // one-cycle pulse: count reached zero

   modport ctl (output reload, output restart, input count, input expired);
   modport cnt (input reload, input restart, output count, output expired);
endinterface

/* File: design/wdt_counter.sv */
`timescale 1ns/100ps
module wdt_counter
(
   input  wire logic  sys_clk,  // system clock
   input  wire logic  reset,    // synchronous reset, active high
   wdt_count_if.cnt   cnt       // reload in, count out
);

   logic [23:0] count_ff;
   logic [23:0] nxt_count;
   logic        expired_ff;
   logic        nxt_expired;

   // down counter; on zero flag expiry and start over from reload
   always_comb
   begin
      nxt_count   = count_ff - 24'h00_0001;
      nxt_expired = 1'b0;
      if (cnt.restart)
      begin
         nxt_count = cnt.reload;
      end
      else if (count_ff == 24'h00_0000)
      begin
         nxt_count   = cnt.reload;
         nxt_expired = 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         count_ff   <= wdt_pkg::RST_RELOAD;
         expired_ff <= 1'b0;
      end
      else
      begin
         count_ff   <= nxt_count;
         expired_ff <= nxt_expired;
      end
   end

   assign cnt.count   = count_ff;
   assign cnt.expired = expired_ff;

endmodule

/* File: dv/wdt_reload_cause_assertions.sv */
`timescale 1ns/100ps
module wdt_reload_cause_checker
(
   input wire logic        sys_clk,       // clock
   input wire logic        reset,         // sync reset
   input wire logic        hsel,          // select
   input wire logic [31:0] haddr,         // address
   input wire logic [1:0]  htrans,        // type
   input wire logic        hwrite,        // write
   input wire logic [31:0] hwdata,        // wdata
   input wire logic        hready,        // ready in
   input wire logic [31:0] hrdata,        // rdata
   input wire logic        hresp,         // response
   input wire logic        por_event,     // power-on
   input wire logic [7:0]  unlock_code,   // code
   input wire logic        unlock_strobe  // strobe
);
   logic       dp_rd_ff;
   logic       por_seen_ff;
   logic       rd_take;
   logic       rd_ctrl;
   logic       wr_ctrl;
   logic [7:0] wbyte;
   // taken transfers, decoded once for all properties
   assign rd_take = hsel && htrans[1] && hready && !hwrite;
   assign rd_ctrl = rd_take && (haddr == 32'h0000_3FC0);
   assign wr_ctrl = hsel && htrans[1] && hready && hwrite && (haddr == 32'h0000_3FC0);
   assign wbyte = hwdata[7:0];
   // read data phase and sticky power-on memory
   always_ff @(posedge sys_clk)
   begin
      dp_rd_ff <= !reset && rd_take;
      por_seen_ff <= !reset && (por_seen_ff || por_event);
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   a_resp_okay:
      assert property (hresp == 1'b0) else $error("response not okay");
   a_idle_zero:
      assert property (!dp_rd_ff |-> hrdata == 32'h0) else $error("read data outside phase");
   a_read_narrow:
      assert property (dp_rd_ff |-> hrdata[31:8] == 24'h0) else $error("upper read bits set");
   a_cause_rsvd:
      assert property (rd_ctrl |=> hrdata[3:0] == 4'h0) else $error("cause low bits set");
   a_rsvd_read:
      assert property (rd_take && (haddr == 32'h0000_3FD0 || haddr == 32'h0000_3FD4)
         |=> hrdata == 32'h0) else $error("reserved read not zero");
   a_strobe_after:
      assert property (wr_ctrl |=> ##1 unlock_strobe) else $error("no unlock strobe");
   a_code_match:
      assert property (unlock_strobe |-> unlock_code == $past(wbyte))
         else $error("unlock code wrong");
   a_por_sticky:
      assert property (rd_ctrl && por_seen_ff |=> hrdata[7]) else $error("power-on bit lost");
endmodule
bind wdt_reload_cause wdt_reload_cause_checker u_chk
(
   .sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
   .hresp, .por_event, .unlock_code, .unlock_strobe
);

/* File: dv/wdt_reload_cause_tb.sv */
`timescale 1ns/100ps
module wdt_reload_cause_tb;
   localparam logic [31:0] A_CTRL  = {wdt_pkg::IDX_CTRL_CAUSE, 2'h0};
   localparam logic [31:0] A_UPPER = {wdt_pkg::IDX_RELOAD_UPPER, 2'h0};
   localparam logic [31:0] A_HIGH  = {wdt_pkg::IDX_RELOAD_HIGH, 2'h0};
   localparam logic [31:0] A_LOW   = {wdt_pkg::IDX_RELOAD_LOW, 2'h0};
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        por_event = 1'b0;
   logic        stop_event = 1'b0;
   logic        ext_event = 1'b0;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, wdt_timeout, unlock_strobe;
   logic [7:0]  unlock_code, v;
   int          n_fail = 0;
   int          n_tests = 0;
   wdt_reload_cause dut
   (
      .sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .por_event, .stop_event,
      .ext_event, .wdt_timeout, .unlock_code, .unlock_strobe
   );
   initial
   begin
      forever #2 sys_clk = ~sys_clk;
   end
   // hready and data looked at mid-cycle, taken at the next rising edge
   task automatic wait_rdy(output logic [31:0] d);
      logic r;
      do
      begin
         @(negedge sys_clk);
         r = hreadyout;
         d = hrdata;
         @(posedge sys_clk);
      end
      while (r !== 1'b1);
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] wd,
                      output logic [7:0] rd);
      logic [31:0] d;
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy(d);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      wait_rdy(d);
      rd = d[7:0];
   endtask
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // count starts at 000400, so the high byte reads 03 a few cycles on
   task automatic t_reset_vals;
      bus(1'b0, A_CTRL, 8'h00, v);
      check8(v, 8'h00);
      bus(1'b0, A_UPPER, 8'h00, v);
      check8(v, 8'h00);
      bus(1'b0, A_HIGH, 8'h00, v);
      check8(v, 8'h03);
   endtask
   // a stored upper byte must not show up in the live count read
   task automatic t_live;
      bus(1'b1, A_UPPER, 8'h7F, v);
      bus(1'b0, A_UPPER, 8'h00, v);
      check8(v, 8'h00);
      bus(1'b1, A_UPPER, 8'h00, v);
   endtask
   task automatic t_reserved;
      bus(1'b1, 32'h0000_3FD0, 8'hFF, v);
      bus(1'b0, 32'h0000_3FD0, 8'h00, v);
      check8(v, 8'h00);
      bus(1'b0, 32'h0000_3FD4, 8'h00, v);
      check8(v, 8'h00);
   endtask
   // reload of 5 gives a timeout every sixth cycle after the refresh
   task automatic t_timeout;
      int n;
      bus(1'b1, A_LOW, 8'h05, v);
      bus(1'b1, A_HIGH, 8'h00, v);
      bus(1'b1, A_CTRL, 8'hA5, v);
      @(negedge sys_clk);
      check8(unlock_code, 8'hA5);
      n = 0;
      while (wdt_timeout !== 1'b1 && n < 40)
      begin
         @(negedge sys_clk);
         n++;
      end
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (wdt_timeout !== 1'b1 && n < 40);
      check8(n[7:0], 8'h06);
      @(posedge sys_clk);
      // count was 5 at the pulse; the read is taken two edges later, at 4
      bus(1'b0, A_LOW, 8'h00, v);
      check8(v, 8'h04);
      bus(1'b0, A_CTRL, 8'h00, v);
      check8(v, 8'h20);
   endtask
   // cause bits are sticky, so each new event adds one bit
   task automatic t_events;
      logic [7:0] exp;
      exp = 8'h20;
      for (int i = 0; i < 3; i++)
      begin
         por_event <= (i == 0);
         stop_event <= (i == 1);
         ext_event <= (i == 2);
         @(posedge sys_clk);
         por_event <= 1'b0;
         stop_event <= 1'b0;
         ext_event <= 1'b0;
         @(posedge sys_clk);
         exp[(i == 0) ? wdt_pkg::POS_POR_CAUSE : (i == 1) ? wdt_pkg::POS_STOP_CAUSE :
             wdt_pkg::POS_EXT_CAUSE] = 1'b1;
         bus(1'b0, A_CTRL, 8'h00, v);
         check8(v, exp);
      end
   endtask
   initial
   begin
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      t_reset_vals();
      t_live();
      t_reserved();
      t_timeout();
      t_events();
      end_of_test();
   end
   // whole run is under a hundred cycles
   initial
   begin
      #20000;
      n_fail++;
      end_of_test();
   end
endmodule
